//--- qpc_mem_model.sv
// Program and data memory standing beside the pipeline.
`timescale 1ns/10ps
module qpc_mem_model
	import qpc_pkg::*;
(
	input  wire logic [15:0] i_prog_addr,
	input  wire logic        i_clk,
	input  wire logic        i_data_rd,
	input  wire logic        i_data_wr,
	input  wire logic [11:0] i_rd_addr,
	input  wire logic [11:0] i_wr_addr,
	input  wire logic [7:0]  i_wdata,
	output logic      [15:0] o_prog_rdata,
	output logic      [7:0]  o_data_rdata
);
	logic [7:0] mem [0:15];
	assign o_prog_rdata = i_prog_addr ^ 16'hA5C3;
	// Outside the read slot the data bus shows the inverted word.
	assign o_data_rdata = i_data_rd ? mem[i_rd_addr[3:0]] : ~mem[i_rd_addr[3:0]];
	always_ff @(posedge i_clk) begin
		if (i_data_wr) begin
			mem[i_wr_addr[3:0]] <= i_wdata;
		end
	end
endmodule

//--- qpc_phase_gen.sv
// Divide-by-four phase generator producing the four phase strobes.
`timescale 1ns/10ps
module qpc_phase_gen
	import qpc_pkg::*;
(
	input  wire logic  i_clk,
	input  wire logic  i_rst_b,
	input  wire logic  i_ce,
	input  wire logic  i_hold,
	output qpc_phases_t o_phases,
	output logic [1:0] o_phase_idx
);

	logic [1:0]  phase_q;
	logic [1:0]  phase_d;
	qpc_phases_t ph_q;
	qpc_phases_t ph_d;

	// ==========================================================================
	// Next phase.
	// ==========================================================================
	always_comb begin
		if (i_hold) begin
			phase_d = QPC_PHASE_RST;
		end else begin
			phase_d = phase_q + 2'h1;
		end
		ph_d.phase_one   = (phase_d == 2'h0);
		ph_d.phase_two   = (phase_d == 2'h1);
		ph_d.phase_three = (phase_d == 2'h2);
		ph_d.phase_four  = (phase_d == 2'h3);
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			phase_q <= QPC_PHASE_RST;
			ph_q    <= 4'h8;
		end else if (i_ce) begin
			phase_q <= phase_d;
			ph_q    <= ph_d;
		end
	end

	assign o_phases    = ph_q;
	assign o_phase_idx = phase_q;

endmodule

//--- qpc_pipeline.sv
// Top of the quad phase clock and two-stage fetch and execute pipeline.
`timescale 1ns/10ps
module qpc_pipeline
	import qpc_pkg::*;
(
	input  wire logic                   i_clk,
	input  wire logic                   i_rst_b,
	input  wire logic                   i_ce,
	input  wire logic                   i_hold_rst,
	input  wire logic [1:0]             i_oscillator_select_bits,
	input  wire logic [QPC_INSN_W-1:0]  i_prog_rdata,
	input  wire logic [QPC_DATA_W-1:0]  i_data_rdata,
	input  wire logic                   i_exec_branch,
	input  wire logic [QPC_PC_W-1:0]    i_exec_target,
	input  wire logic                   i_exec_wr_en,
	input  wire logic [QPC_DADDR_W-1:0] i_exec_addr,
	input  wire logic [QPC_DATA_W-1:0]  i_exec_wdata,
	output logic                        o_phase_one,
	output logic                        o_phase_two,
	output logic                        o_phase_three,
	output logic                        o_phase_four,
	output logic [QPC_PC_W-1:0]         o_prog_addr,
	output logic                        o_prog_rd,
	output logic [QPC_INSN_W-1:0]       o_instruction_latch,
	output logic                        o_insn_valid,
	output logic                        o_decode,
	output logic [QPC_DATA_W-1:0]       o_operand,
	output logic                        o_data_rd,
	output logic                        o_data_wr,
	output logic [QPC_DADDR_W-1:0]      o_data_addr,
	output logic [QPC_DATA_W-1:0]       o_data_wdata,
	output logic                        o_clock_output_pin,
	output logic                        o_clock_output_oe_b
);

	qpc_phases_t ph;
	logic [1:0]  phase_idx;

	qpc_phase_gen u_phase (
		.i_clk       (i_clk),
		.i_rst_b     (i_rst_b),
		.i_ce        (i_ce),
		.i_hold      (i_hold_rst),
		.o_phases    (ph),
		.o_phase_idx (phase_idx)
	);

	// ==========================================================================
	// Pipeline state.
	// ==========================================================================
	typedef struct packed {
		logic [QPC_PC_W-1:0]    pc;
		logic [QPC_INSN_W-1:0]  fetch_buf;
		logic                   fetch_ok;
		logic [QPC_INSN_W-1:0]  ir;
		logic                   ir_ok;
		logic                   flush;
		logic                   prog_rd;
		logic                   decode;
		logic [QPC_DATA_W-1:0]  operand;
		logic                   data_rd;
		logic                   data_wr;
		logic [QPC_DADDR_W-1:0] daddr;
		logic [QPC_DATA_W-1:0]  wdata;
		logic                   clk_out;
		logic                   clk_oe_b;
	} qpc_pipe_t;

	qpc_pipe_t s_q;
	qpc_pipe_t s_d;
	logic      crystal;
	logic      running;

	always_comb begin
		s_d     = s_q;
		running = !i_hold_rst;
		crystal = (i_oscillator_select_bits == QPC_OSC_LF) ||
		          (i_oscillator_select_bits == QPC_OSC_XT);
		s_d.prog_rd = 1'b0;
		s_d.decode  = 1'b0;
		s_d.data_rd = 1'b0;
		s_d.data_wr = 1'b0;
		if (running) begin
			if (ph.phase_one) begin
				s_d.pc       = s_q.pc + 16'h0001;
				s_d.ir       = s_q.fetch_buf;
				s_d.ir_ok    = s_q.fetch_ok && !s_q.flush;
				s_d.fetch_ok = 1'b0;
				s_d.flush    = 1'b0;
			end
			if (ph.phase_two && s_q.ir_ok) begin
				s_d.decode  = 1'b1;
				s_d.data_rd = 1'b1;
				s_d.daddr   = i_exec_addr;
			end
			if (ph.phase_three && s_q.ir_ok) begin
				s_d.operand = i_data_rdata;
			end
			if (ph.phase_four) begin
				s_d.prog_rd   = 1'b1;
				s_d.fetch_buf = i_prog_rdata;
				s_d.fetch_ok  = 1'b1;
				if (s_q.ir_ok) begin
					s_d.data_wr = i_exec_wr_en;
					s_d.daddr   = i_exec_addr;
					s_d.wdata   = i_exec_wdata;
					if (i_exec_branch) begin
						// Phase one adds one, so the next fetch lands on the target.
						s_d.pc    = i_exec_target - 16'h0001;
						s_d.flush = 1'b1;
					end
				end
			end
		end
		// The clock output rests low while the phase generator is held.
		s_d.clk_out  = !crystal && running && (phase_idx == 2'h0 ||
		               phase_idx == 2'h1);
		s_d.clk_oe_b = crystal;
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s_q          <= '0;
			s_q.pc       <= QPC_PC_RST;
			s_q.ir       <= QPC_INSN_NOP;
			s_q.clk_oe_b <= 1'b1;
		end else if (i_ce) begin
			s_q <= s_d;
		end
	end

	// ==========================================================================
	// Outputs.
	// ==========================================================================
	assign o_phase_one         = ph.phase_one;
	assign o_phase_two         = ph.phase_two;
	assign o_phase_three       = ph.phase_three;
	assign o_phase_four        = ph.phase_four;
	assign o_prog_addr         = s_q.pc;
	assign o_prog_rd           = s_q.prog_rd;
	assign o_instruction_latch = s_q.ir;
	assign o_insn_valid        = s_q.ir_ok;
	assign o_decode            = s_q.decode;
	assign o_operand           = s_q.operand;
	assign o_data_rd           = s_q.data_rd;
	assign o_data_wr           = s_q.data_wr;
	assign o_data_addr         = s_q.daddr;
	assign o_data_wdata        = s_q.wdata;
	assign o_clock_output_pin  = s_q.clk_out;
	assign o_clock_output_oe_b = s_q.clk_oe_b;

endmodule

//--- qpc_pipeline_sva.sv
// Checker of phase order, fetch, write and clock output timing.
`timescale 1ns/10ps
module qpc_pipeline_sva
	import qpc_pkg::*;
(
	input wire logic                i_clk,
	input wire logic                i_rst_b,
	input wire logic                i_ce,
	input wire logic                i_hold_rst,
	input wire logic [1:0]          i_oscillator_select_bits,
	input wire logic                i_exec_branch,
	input wire logic                i_exec_wr_en,
	input wire logic                o_phase_one,
	input wire logic                o_phase_two,
	input wire logic                o_phase_three,
	input wire logic                o_phase_four,
	input wire logic [QPC_PC_W-1:0] o_prog_addr,
	input wire logic                o_prog_rd,
	input wire logic                o_insn_valid,
	input wire logic                o_decode,
	input wire logic                o_data_rd,
	input wire logic                o_data_wr,
	input wire logic                o_clock_output_pin,
	input wire logic                o_clock_output_oe_b
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b || !i_ce);
	sequence s_phase_run;
		o_phase_two ##1 o_phase_three ##1 o_phase_four ##1 o_phase_one;
	endsequence
	sequence s_wave;
		o_clock_output_pin [*2] ##1 !o_clock_output_pin [*2] ##1
			o_clock_output_pin;
	endsequence
	a_phase_order: assert property (o_phase_one && !i_hold_rst |=>
		s_phase_run)
		else $error("Phase order broken.");
	a_fetch_strobe: assert property (o_prog_rd |-> o_phase_one)
		else $error("Fetch strobe outside phase one.");
	a_read_slot: assert property (o_data_rd |->
		o_phase_three && o_decode)
		else $error("Operand read outside phase three.");
	a_hold_phase: assert property (i_hold_rst |=> o_phase_one)
		else $error("Phase left phase one while held.");
	a_pc_step: assert property (o_phase_two |->
		o_prog_addr == $past(o_prog_addr) + 16'h1)
		else $error("Program counter did not step once.");
	a_decode_slot: assert property (o_decode |-> o_phase_three)
		else $error("Decode outside its phase.");
	a_write_slot: assert property (o_phase_four && o_insn_valid &&
		i_exec_wr_en |=> o_data_wr && o_phase_one)
		else $error("Destination write missing.");
	a_branch_flush: assert property (o_phase_four && o_insn_valid &&
		i_exec_branch |=> ##1 !o_insn_valid [*3])
		else $error("Fetched word not flushed.");
	a_pad_drive: assert property (1'b1 |=>
		o_clock_output_oe_b == ($past(i_oscillator_select_bits) < 2'h2) &&
		(!o_clock_output_oe_b || !o_clock_output_pin))
		else $error("Clock output drive wrong for mode.");
	a_clk_period: assert property (i_oscillator_select_bits[1] &&
		$rose(o_clock_output_pin) |-> s_wave)
		else $error("Clock output period wrong.");
endmodule

//--- qpc_pipeline_tb_top.sv
// Bench driving the quad phase pipeline with its memory partner.
`timescale 1ns/10ps
module qpc_pipeline_tb_top;
	import qpc_pkg::*;
	logic        clk = 1'b0, rst_b = 1'b0, hold = 1'b0, br = 1'b0, wen = 1'b0;
	logic        ce = 1'b1;
	logic [1:0]  sel = 2'h0;
	logic [15:0] tgt = 16'h0000, pc, prd, lat;
	logic [11:0] adr = 12'h000, dadr;
	logic [7:0]  wd = 8'h00, rd, opd, dwd;
	logic        p1, p2, p3, p4, vld, drd, dwr, pin, oe_b;
	wire  [4:1]  ph = {p4, p3, p2, p1};
	int          mismatches = 0, cmp_count = 0, cyc = 0;
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			mismatches++;
			finish_test();
		end
	end
	qpc_pipeline DUT (.i_clk(clk), .i_rst_b(rst_b), .i_ce(ce),
		.i_hold_rst(hold), .i_oscillator_select_bits(sel), .i_prog_rdata(prd),
		.i_data_rdata(rd), .i_exec_branch(br), .i_exec_target(tgt),
		.i_exec_wr_en(wen), .i_exec_addr(adr), .i_exec_wdata(wd),
		.o_phase_one(p1), .o_phase_two(p2), .o_phase_three(p3),
		.o_phase_four(p4), .o_prog_addr(pc), .o_prog_rd(),
		.o_instruction_latch(lat), .o_insn_valid(vld), .o_decode(),
		.o_operand(opd), .o_data_rd(drd), .o_data_wr(dwr), .o_data_addr(dadr),
		.o_data_wdata(dwd), .o_clock_output_pin(pin), .o_clock_output_oe_b(oe_b));
	qpc_mem_model u_mem (.i_clk(clk), .i_prog_addr(pc), .i_data_rd(drd),
		.i_data_wr(dwr), .i_rd_addr(dadr), .i_wr_addr(dadr), .i_wdata(dwd),
		.o_prog_rdata(prd), .o_data_rdata(rd));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wph(input int n);
		do @(posedge clk) #2; while (ph[n] !== 1'b1);
	endtask
	task automatic do_reset();
		rst_b = 1'b0;
		repeat (20) @(posedge clk);
		#2 rst_b = 1'b1;
	endtask
	task automatic t_modes();
		int r;
		for (int m = 0; m < 4; m++) begin
			sel = m[1:0];
			do_reset();
			r = 0;
			repeat (4) @(posedge clk);
			repeat (16) @(posedge clk) #2 r += (pin === 1'b1);
			chk(oe_b, (m < 2) ? 16'h1 : 16'h0);
			chk(r[15:0], (m < 2) ? 16'h0 : 16'h8);
		end
	endtask
	task automatic t_hold();
		do_reset();
		hold = 1'b1;
		repeat (5) @(posedge clk) #2 chk(ph, 4'h1);
		hold = 1'b0;
	endtask
	task automatic t_fetch();
		logic [15:0] p;
		wph(2);
		p = pc;
		repeat (3) begin
			wph(2);
			chk(pc, p + 16'h1);
			chk(lat, p ^ 16'hA5C3);
			chk(vld, 16'h1);
			p = pc;
		end
	endtask
	task automatic t_write(input logic [11:0] a, input logic [7:0] d);
		wph(2);
		adr = a;
		wd = d;
		wen = 1'b1;
		wph(1);
		wen = 1'b0;
		chk(dwr, 16'h1);
		chk(dadr, a);
		chk(dwd, d);
		wph(4);
		chk(opd, d);
	endtask
	task automatic t_freeze();
		logic [15:0] p;
		wph(4);
		p = pc;
		ce = 1'b0;
		repeat (3) @(posedge clk) #2 begin
			chk(ph, 4'h8);
			chk(pc, p);
		end
		ce = 1'b1;
		@(posedge clk) #2 chk(ph, 4'h1);
	endtask
	task automatic t_branch(input logic [15:0] t);
		wph(4);
		br = 1'b1;
		tgt = t;
		wph(2);
		br = 1'b0;
		chk(pc, t);
		chk(vld, 16'h0);
		wph(2);
		chk(vld, 16'h1);
		chk(lat, t ^ 16'hA5C3);
	endtask
	task automatic finish_test();
		if (mismatches == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		t_modes();
		t_hold();
		t_fetch();
		t_write(12'hFFF, 8'h5A);
		t_write(12'h000, 8'hA5);
		t_freeze();
		t_branch(16'hFFFF);
		t_fetch();
		finish_test();
	end
endmodule
bind qpc_pipeline qpc_pipeline_sva u_sva (.i_clk(i_clk), .i_rst_b(i_rst_b),
	.i_ce(i_ce),
	.i_hold_rst(i_hold_rst), .i_oscillator_select_bits(i_oscillator_select_bits),
	.i_exec_branch(i_exec_branch), .i_exec_wr_en(i_exec_wr_en),
	.o_phase_one(o_phase_one), .o_phase_two(o_phase_two),
	.o_phase_three(o_phase_three), .o_phase_four(o_phase_four),
	.o_prog_addr(o_prog_addr), .o_insn_valid(o_insn_valid),
	.o_decode(o_decode), .o_data_wr(o_data_wr),
	.o_prog_rd(o_prog_rd), .o_data_rd(o_data_rd),
	.o_clock_output_pin(o_clock_output_pin),
	.o_clock_output_oe_b(o_clock_output_oe_b));

//--- qpc_pkg.sv
// Package of constants and types for the quad phase clock and fetch pipeline.
// Operation
// - Divide input clock by four into four ordered non-overlapping phases.
// - Program counter increments once per cycle in phase one.
// - Next instruction word is read and captured by end of phase four.
// - Instruction latch loads in phase one; decode and execute follow.
// - Operand read happens in phase two, destination write in phase four; the code reads the operand in phase three and strobes the write in phase one.
// - Fetch overlaps execution so plain instructions finish one per cycle.
// - A program counter change flushes the fetched word; costs two cycles.
// - External clock mode drives clock output with period four clocks.
// - Resistor-capacitor mode drives clock output at input rate over four.
// - A two-bit configuration field selects one of four oscillator modes.
// - Reset holds the phase generator in phase one.
package qpc_pkg;

	// ==========================================================================
	// Widths and reset values.
	// ==========================================================================
	localparam int          QPC_PC_W      = 16;
	localparam int          QPC_INSN_W    = 16;
	localparam int          QPC_DATA_W    = 8;
	localparam int          QPC_DADDR_W   = 12;
	localparam logic [15:0] QPC_PC_RST    = 16'h0000;
	localparam logic [15:0] QPC_INSN_NOP  = 16'h0000;
	localparam logic [1:0]  QPC_PHASE_RST = 2'h0;
	localparam logic [1:0]  QPC_PHASE_LST = 2'h3;

	// ==========================================================================
	// Oscillator select encodings.
	// ==========================================================================
	localparam logic [1:0] QPC_OSC_LF = 2'h0;
	localparam logic [1:0] QPC_OSC_XT = 2'h1;
	localparam logic [1:0] QPC_OSC_EC = 2'h2;
	localparam logic [1:0] QPC_OSC_RC = 2'h3;

	// ==========================================================================
	// Types.
	// ==========================================================================
	typedef struct packed {
		logic phase_one;
		logic phase_two;
		logic phase_three;
		logic phase_four;
	} qpc_phases_t;

	typedef struct packed {
		logic                   valid;
		logic [QPC_PC_W-1:0]    target;
	} qpc_branch_t;

	typedef struct packed {
		logic                   wr_en;
		logic [QPC_DADDR_W-1:0] addr;
		logic [QPC_DATA_W-1:0]  wdata;
	} qpc_dwr_t;

endpackage
